//--- rtl/pcn_defs.svh
// Constants of the pin connectivity NAND chain block.
// Assumes it is included by bare name in package and design files.
`ifndef PCN_DEFS_SVH
`define PCN_DEFS_SVH

// Chain length and pin positions, counted from the first chain input
`define PCN_CHAIN_LEN       17
`define PCN_IDX_LED4_A      0
`define PCN_IDX_LED2_A      5
`define PCN_IDX_LED2_B      6

// Strap code {led2_out_b, led2_out_a, led4_out_a} that selects chain mode
`define PCN_STRAP_NAND      3'h5

// Reset value of the pin drivers and the all-high chain input pattern
`define PCN_PIN_RST         17'h00000
`define PCN_ALL_HIGH        17'h1FFFF

`endif

//--- rtl/pcn_pkg.sv
// Types and helper functions of the pin connectivity NAND chain block.
// Assumes pcn_defs.svh is on the include path.
`include "pcn_defs.svh"

package pcn_pkg;

   // Mode sequence after reset: sample straps, then one of two modes
   typedef enum logic [1:0] {
      PCN_STRAP = 2'h0,
      PCN_FUNC  = 2'h1,
      PCN_NAND  = 2'h2
   } pcn_mode_type;

   typedef logic [`PCN_CHAIN_LEN-1:0] pcn_pins_type;

   // Level the chain output shows once k leading inputs are low
   function automatic logic pcn_expect_level(input logic [4:0] k);
      return ~k[0];
   endfunction

   // Count of leading low inputs when the pins form a low prefix, else 31
   function automatic logic [4:0] pcn_low_prefix(input pcn_pins_type pins);
      logic [4:0] cnt;
      logic       seen_high;
      logic       bad;
      cnt       = 5'h00;
      seen_high = 1'b0;
      bad       = 1'b0;
      for (int i = 0; i < `PCN_CHAIN_LEN; i++) begin
         if (pins[i]) begin
            seen_high = 1'b1;
         end else if (seen_high) begin
            bad = 1'b1;
         end else begin
            cnt = cnt + 5'h01;
         end
      end
      return bad ? 5'h1F : cnt;
   endfunction

endpackage

//--- rtl/pcn_chain_if.sv
// Carrier between the mode logic and the NAND chain.
// Assumes one source of chain inputs and one chain.
`timescale 1ns/10ps
`default_nettype none
`include "pcn_defs.svh"

interface pcn_chain_if;
   logic [`PCN_CHAIN_LEN-1:0] chain_in;
   logic                      chain_out;

   modport src   (output chain_in, input chain_out);
   modport chain (input chain_in, output chain_out);
endinterface

`default_nettype wire

//--- rtl/pcn_nand_chain.sv
// Purely combinational chain of nested NAND gates.
// Assumes inputs already in chain order, first input at bit 0.
`timescale 1ns/10ps
`default_nettype none
`include "pcn_defs.svh"

module pcn_nand_chain (
   pcn_chain_if.chain ch
);

   logic [`PCN_CHAIN_LEN-1:0] gate_out;

   // First gate sees a constant high on its upper leg
   assign gate_out[0] = ~(ch.chain_in[0] & 1'b1); // RQ1

   for (genvar i = 1; i < `PCN_CHAIN_LEN; i++) begin : g_stage
      assign gate_out[i] = ~(ch.chain_in[i] & gate_out[i-1]); // RQ1
   end

   // Output buffer inverts so that all-high inputs give a high pin
   assign ch.chain_out = ~gate_out[`PCN_CHAIN_LEN-1]; // RQ3 RQ5 RQ6

endmodule

`default_nettype wire

//--- rtl/pcn_nand_top.sv
// Top of the pin connectivity NAND chain block.
// Assumes pin inputs are synchronous to clk_sys and pads resolve oe.
//
// Behaviour
// RQ1: NAND chain over inputs drives interrupt pin
// RQ2: Straps at reset select chain test mode
// RQ3: All inputs high gives high chain output
// RQ4: Inputs chained in fixed pin order, output last
// RQ5: First input low makes output fall
// RQ6: Second low rises output, third falls again
// RQ7: Tester keeps earlier inputs low, continues onward
// RQ8: Tester flags pin without output toggle as faulty
// RQ9: Combinational output; high for even lows
`timescale 1ns/10ps
`default_nettype none
`include "pcn_defs.svh"

module pcn_nand_top
   import pcn_pkg::*;
(
   input  wire logic                      clk_sys,
   input  wire logic                      rst,
   input  wire logic [`PCN_CHAIN_LEN-1:0] pin_in,
   input  wire logic [`PCN_CHAIN_LEN-1:0] func_out,
   input  wire logic [`PCN_CHAIN_LEN-1:0] func_oe,
   input  wire logic                      func_irq_n,
   output var  logic [`PCN_CHAIN_LEN-1:0] pin_out,
   output var  logic [`PCN_CHAIN_LEN-1:0] pin_oe,
   output logic                           chain_output_pin_out,
   output var  logic                      chain_output_pin_oe,
   output var  logic                      nand_mode
);

   ////////////////////////////////////////////////////////////////////////
   // Mode selection from straps

   pcn_mode_type mode_reg;
   pcn_mode_type mode_next;
   logic [2:0]   strap_code;
   logic         strap_hit;

   assign strap_code = {pin_in[`PCN_IDX_LED2_B], pin_in[`PCN_IDX_LED2_A],
                        pin_in[`PCN_IDX_LED4_A]};
   assign strap_hit  = (strap_code == `PCN_STRAP_NAND); // RQ2

   always_comb begin
      case (mode_reg)
         PCN_STRAP: begin
            mode_next = strap_hit ? PCN_NAND : PCN_FUNC; // RQ2
         end
         PCN_FUNC: begin
            mode_next = PCN_FUNC;
         end
         PCN_NAND: begin
            mode_next = PCN_NAND;
         end
         default: begin
            mode_next = PCN_STRAP;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_reg <= PCN_STRAP;
      end else begin
         mode_reg <= mode_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers

   logic                      test_mode;
   logic                      strap_phase;
   logic [`PCN_CHAIN_LEN-1:0] pin_oe_next;
   logic                      irq_oe_next;
   logic                      irq_func_reg;

   assign test_mode   = (mode_reg == PCN_NAND);
   assign strap_phase = (mode_next == PCN_STRAP) || (mode_reg == PCN_STRAP);

   // Chain pins turn into inputs in test mode and while straps are read
   assign pin_oe_next = (mode_next == PCN_FUNC) ? func_oe : `PCN_PIN_RST; // RQ1
   assign irq_oe_next = (mode_next != PCN_STRAP);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_out             <= `PCN_PIN_RST;
         pin_oe              <= `PCN_PIN_RST;
         chain_output_pin_oe <= 1'b0;
         irq_func_reg        <= 1'b1;
         nand_mode           <= 1'b0;
      end else begin
         pin_out             <= func_out;
         pin_oe              <= pin_oe_next;
         chain_output_pin_oe <= irq_oe_next;
         irq_func_reg        <= func_irq_n;
         nand_mode           <= (mode_next == PCN_NAND);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // NAND chain; its output bypasses any flip-flop

   pcn_chain_if chain_bus ();

   assign chain_bus.chain_in = pin_in; // RQ4

   pcn_nand_chain u_chain (
      .ch (chain_bus.chain)
   );

   // No clock in the chain path, so a change propagates at once
   assign chain_output_pin_out = test_mode ? chain_bus.chain_out // RQ9
                                           : irq_func_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys);
   endclocking

   default disable iff (rst);

   logic [4:0] low_cnt;
   logic       low_prefix;

   assign low_cnt    = pcn_low_prefix(pin_in);
   assign low_prefix = (low_cnt != 5'h1F);

   mode_enter_a: assert property ( // RQ2
      (mode_reg == PCN_STRAP) && strap_hit |=> nand_mode && test_mode [*3])
      else $error("strapped chain mode was not entered");

   mode_skip_a: assert property ( // RQ2
      (mode_reg == PCN_STRAP) && !strap_hit |=> !nand_mode [*3])
      else $error("chain mode entered without its strap code");

   pins_input_a: assert property ( // RQ1
      test_mode |-> (pin_oe == `PCN_PIN_RST) && chain_output_pin_oe)
      else $error("chain pins not released or output not driven");

   all_high_a: assert property ( // RQ3
      test_mode && (pin_in == `PCN_ALL_HIGH) |-> chain_output_pin_out)
      else $error("all inputs high but chain output low");

   first_fall_a: assert property ( // RQ5
      test_mode && $past(test_mode) && ($past(pin_in) == `PCN_ALL_HIGH)
      && (pin_in == 17'h1FFFE) |-> $past(chain_output_pin_out)
      && !chain_output_pin_out)
      else $error("first input low did not make the output fall");

   second_rise_a: assert property ( // RQ6
      test_mode && (pin_in == 17'h1FFFE) ##1 test_mode && (pin_in == 17'h1FFFC)
      |-> chain_output_pin_out && !$past(chain_output_pin_out))
      else $error("second input low did not make the output rise");

   third_fall_a: assert property ( // RQ6
      test_mode && (pin_in == 17'h1FFFC) ##1 test_mode && (pin_in == 17'h1FFF8)
      |-> !chain_output_pin_out && $past(chain_output_pin_out))
      else $error("third input low did not make the output fall");

   pin_order_a: assert property ( // RQ4
      test_mode && (pin_in == 17'h1FFFD) |-> chain_output_pin_out)
      else $error("second chain input sits in the wrong place");

   parity_level_a: assert property ( // RQ9
      test_mode && low_prefix
      |-> chain_output_pin_out == pcn_expect_level(low_cnt))
      else $error("chain output level wrong for count of low inputs");

   full_walk_c: cover property (
      test_mode && (pin_in == `PCN_ALL_HIGH) ##[1:40]
      test_mode && (pin_in == `PCN_PIN_RST));

   first_step_c: cover property (
      test_mode && (pin_in == `PCN_ALL_HIGH) ##1 (pin_in == 17'h1FFFE));

   func_mode_c: cover property (
      (mode_reg == PCN_STRAP) ##1 (mode_reg == PCN_FUNC));

endmodule

`default_nettype wire

//--- test/pcn_board_tester.sv
// Board tester model driving the chain pins.
// Assumes push-pull pins and one chain output.
`timescale 1ns/10ps
`default_nettype none
`include "pcn_defs.svh"
module pcn_board_tester
   import pcn_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         strap_en,
   input  wire logic [2:0]   strap_code,
   input  wire logic         rand_en,
   input  wire pcn_pins_type rand_pins,
   input  wire logic [4:0]   low_count,
   input  wire logic         chain_level,
   output var  pcn_pins_type pin_drive,
   output var  logic         fault_seen
);
   pcn_pins_type prev_reg;
   logic         level_reg;
   logic         walk_reg;
   logic         walk_old_reg;
   wire          step_seen = walk_reg && walk_old_reg && (pin_drive != prev_reg);
   wire          no_toggle = step_seen && (chain_level === level_reg);
   always_ff @(posedge clk_sys) begin
      if (strap_en) begin
         pin_drive <= {10'h3FF, strap_code[2:1], 4'hF, strap_code[0]};
      end else if (rand_en) begin
         pin_drive <= rand_pins;
      end else begin
         pin_drive <= `PCN_ALL_HIGH << low_count;
      end
      walk_reg     <= !strap_en && !rand_en;
      walk_old_reg <= walk_reg;
      prev_reg     <= pin_drive;
      level_reg    <= chain_level;
      fault_seen   <= !strap_en && (fault_seen || no_toggle);
   end
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench of the NAND chain top.
// Assumes the tester model drives every chain pin.
`timescale 1ns/10ps
`default_nettype none
`include "pcn_defs.svh"
module tb;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        strap_en = 1'b1;
   logic        rand_en = 1'b0;
   logic [2:0]  strap_code = 3'h5;
   logic [4:0]  low_count = 5'h00;
   logic [16:0] rand_pins = 17'h00000;
   logic [16:0] func_out = 17'h00000;
   logic [16:0] func_oe = 17'h00000;
   logic        func_irq_n = 1'b1;
   logic [16:0] pin_in, pin_out, pin_oe, r, a, b;
   logic        chain_output_pin_out, chain_output_pin_oe, nand_mode, fault_seen, g, c;
   logic [36:0] exp_q[$], mask_q[$], got;
   int          bad_count = 0, n_compared = 0, cycles = 0;
   always #2.5 clk_sys = ~clk_sys;
   pcn_nand_top u_dut (.clk_sys, .rst, .pin_in, .func_out, .func_oe, .func_irq_n,
      .pin_out, .pin_oe, .chain_output_pin_out, .chain_output_pin_oe, .nand_mode);
   pcn_board_tester u_tester (.clk_sys, .strap_en, .strap_code, .rand_en, .rand_pins,
      .low_count, .chain_level(chain_output_pin_out), .pin_drive(pin_in), .fault_seen);
   task automatic stop_test;
      if (bad_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic note(input logic [36:0] e, input logic [36:0] m);
      exp_q.push_back(e & m);
      mask_q.push_back(m);
   endtask
   always @(negedge clk_sys) begin
      if (exp_q.size() > 0) begin
         got = {pin_out, pin_oe, chain_output_pin_oe, chain_output_pin_out, nand_mode};
         got = got & mask_q.pop_front();
         n_compared++;
         if (got !== exp_q[0]) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp_q[0]);
         end
         void'(exp_q.pop_front());
      end
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 2000) begin
         bad_count++;
         stop_test;
      end
   end
   task automatic do_reset(input logic [2:0] code);
      @(posedge clk_sys);
      strap_en <= 1'b1;
      strap_code <= code;
      rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      note(37'h2, {37{1'b1}});
      rst <= 1'b0;
      @(posedge clk_sys);
      note({34'h0, 1'b1, 1'b0, code == 3'h5}, 37'h5);
      strap_en <= 1'b0;
   endtask
   task automatic walk(input int last);
      for (int k = 0; k <= last; k++) begin
         low_count <= k[4:0];
         repeat (2) @(posedge clk_sys);
         note({35'h1, ~k[0], 1'b1}, 37'hFFFFF);
      end
   endtask
   initial begin
      void'($urandom(32'hdb94e21a));
      do_reset(3'h5);
      walk(17);
      @(posedge clk_sys);
      n_compared++;
      if (fault_seen !== 1'b0) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, fault_seen, 1'b0);
      end
      rand_en <= 1'b1;
      repeat (20) begin
         r = 17'($urandom);
         rand_pins <= r;
         repeat (2) @(posedge clk_sys);
         g = 1'b1;
         for (int i = 0; i < 17; i++) g = ~(r[i] & g);
         note({35'h1, ~g, 1'b1}, 37'hFFFFF);
      end
      do_reset(3'h2);
      repeat (10) begin
         a = 17'($urandom);
         b = 17'($urandom);
         c = 1'($urandom);
         func_out <= a;
         func_oe <= b;
         func_irq_n <= c;
         rand_pins <= ~a;
         repeat (2) @(posedge clk_sys);
         note({a, b, 1'b1, c, 1'b0}, {37{1'b1}});
      end
      rand_en <= 1'b0;
      do_reset(3'h5);
      walk(2);
      @(posedge clk_sys);
      stop_test;
   end
endmodule
`default_nettype wire
